// file: logic/lsd_pkg.sv
// line state detector shared constants and types
// assumes one 250 MHz clock and an APB register bus

package lsd_pkg;

  // apb map, byte addresses
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] THRESH_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] EVENT_OFF = 8'h0C;
  localparam logic [7:0] MASK_OFF = 8'h10;
  localparam logic [7:0] LIVE_OFF = 8'h14;

  // control fields
  localparam int CTRL_ON_BIT = 0;
  localparam logic CTRL_ON_RESET = 1'b1;

  // threshold fields, percent of rated value
  localparam int VTH_LSB = 0;
  localparam int ITH_LSB = 8;
  localparam logic [7:0] VTH_RESET = 8'h3C;
  localparam logic [7:0] ITH_RESET = 8'h0A;
  localparam logic [7:0] VTH_MIN = 8'h0A;
  localparam logic [7:0] VTH_MAX = 8'h64;
  localparam logic [7:0] ITH_MIN = 8'h08;
  localparam logic [7:0] ITH_MAX = 8'h64;

  // status and event bit positions
  localparam int ST_VHIGH_LSB = 0;
  localparam int ST_IHIGH_LSB = 3;
  localparam int ST_DEAD_BIT = 6;
  localparam int ST_LIVE_BIT = 7;
  localparam int ST_LIVE_QUAL_BIT = 8;
  localparam int EV_WIDTH = 4;
  localparam logic [EV_WIDTH-1:0] EV_RESET = 4'h0;

  // live qualification time
  localparam int CLK_MHZ = 250;
  localparam int LIVE_QUAL_MS = 200;
  localparam int LIVE_QUAL_CYC = LIVE_QUAL_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 26;

  localparam int MAG_W = 8;

  typedef enum logic [1:0] {LSD_OFF, LSD_NEUTRAL, LSD_DEAD, LSD_LIVE} lsd_state_t;

endpackage

// file: logic/lsd_cmp_if.sv
// comparator bundle between detector top and phase comparator
// assumes the producer is on the same clock

`timescale 1ns/100ps

interface lsd_cmp_if;
  logic [3*lsd_pkg::MAG_W-1:0] volt;
  logic [3*lsd_pkg::MAG_W-1:0] curr;
  logic [lsd_pkg::MAG_W-1:0] vth;
  logic [lsd_pkg::MAG_W-1:0] ith;
  logic [2:0] v_high;
  logic [2:0] i_high;
  logic [2:0] v_low;
  logic [2:0] i_low;
  modport top (output volt, curr, vth, ith, input v_high, i_high, v_low, i_low);
  modport cmp (input volt, curr, vth, ith, output v_high, i_high, v_low, i_low);
endinterface

// file: logic/lsd_phase_cmp.sv
// per-phase magnitude comparators, purely combinational
// assumes magnitudes in percent of rated value

`timescale 1ns/100ps

module lsd_phase_cmp (
  lsd_cmp_if.cmp c
);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      assign c.v_high[g] = c.volt[g*lsd_pkg::MAG_W +: lsd_pkg::MAG_W] > c.vth;
      assign c.v_low[g] = c.volt[g*lsd_pkg::MAG_W +: lsd_pkg::MAG_W] < c.vth;
      assign c.i_high[g] = c.curr[g*lsd_pkg::MAG_W +: lsd_pkg::MAG_W] > c.ith;
      // current below limit, equal is not below
      assign c.i_low[g] = c.curr[g*lsd_pkg::MAG_W +: lsd_pkg::MAG_W] < c.ith;
    end
  endgenerate

endmodule

// file: logic/line_state_detector.sv
// line state detector top: flags, dead/live decision, apb registers
// assumes magnitudes arrive synchronous to CLOCK from the front end
//
// Chosen here: register access over APB and the register addresses.

`timescale 1ns/100ps

module line_state_detector (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CE,
  // measurement inputs
  input wire logic [7:0] PHASE1_VOLTAGE,
  input wire logic [7:0] PHASE2_VOLTAGE,
  input wire logic [7:0] PHASE3_VOLTAGE,
  input wire logic [7:0] PHASE1_CURRENT,
  input wire logic [7:0] PHASE2_CURRENT,
  input wire logic [7:0] PHASE3_CURRENT,
  input wire logic DETECTOR_BLOCK_IN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // line state outputs
  output logic PHASE1_VOLTAGE_HIGH,
  output logic PHASE2_VOLTAGE_HIGH,
  output logic PHASE3_VOLTAGE_HIGH,
  output logic PHASE1_CURRENT_HIGH,
  output logic PHASE2_CURRENT_HIGH,
  output logic PHASE3_CURRENT_HIGH,
  output logic LINE_DEAD_OUT,
  output logic LINE_LIVE_OUT,
  output logic LINE_LIVE_QUALIFIED,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic on;
    logic [7:0] vth;
    logic [7:0] ith;
    logic [2:0] v_high;
    logic [2:0] i_high;
    lsd_pkg::lsd_state_t state;
    logic [lsd_pkg::CNT_W-1:0] live_cnt;
    logic live_qual;
    logic [lsd_pkg::EV_WIDTH-1:0] events;
    logic [lsd_pkg::EV_WIDTH-1:0] mask;
    logic [31:0] rdata;
  } lsd_regs_t;

  lsd_regs_t r;
  lsd_regs_t next_r;

  lsd_cmp_if cmp_bus ();

  assign cmp_bus.volt = {PHASE3_VOLTAGE, PHASE2_VOLTAGE, PHASE1_VOLTAGE};
  assign cmp_bus.curr = {PHASE3_CURRENT, PHASE2_CURRENT, PHASE1_CURRENT};
  assign cmp_bus.vth = r.vth;
  assign cmp_bus.ith = r.ith;

  lsd_phase_cmp u_cmp (
    .c(cmp_bus.cmp)
  );

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [7:0] clip_pct(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
    clip_pct = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  logic enabled;
  logic dead_cond;
  logic live_cond;
  logic apb_wr;
  logic apb_rd;
  logic apb_setup_rd;
  logic addr_ok;
  logic [3:0] new_ev;
  lsd_pkg::lsd_state_t new_state;

  assign enabled = r.on && !DETECTOR_BLOCK_IN;
  assign dead_cond = &cmp_bus.v_low && &cmp_bus.i_low;
  assign live_cond = &cmp_bus.v_high;

  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && PENABLE && !PWRITE;
  assign apb_setup_rd = PSEL && !PENABLE && !PWRITE;
  assign addr_ok = (PADDR == lsd_pkg::CTRL_OFF) || (PADDR == lsd_pkg::THRESH_OFF) ||
    (PADDR == lsd_pkg::STATUS_OFF) || (PADDR == lsd_pkg::EVENT_OFF) ||
    (PADDR == lsd_pkg::MASK_OFF) || (PADDR == lsd_pkg::LIVE_OFF);

  always_comb begin
    next_r = r;
    new_ev = 4'h0;
    if (!enabled) begin
      new_state = lsd_pkg::LSD_OFF;
    end else if (dead_cond) begin
      new_state = lsd_pkg::LSD_DEAD;
    end else if (live_cond) begin
      new_state = lsd_pkg::LSD_LIVE;
    end else begin
      new_state = lsd_pkg::LSD_NEUTRAL;
    end
    next_r.v_high = enabled ? cmp_bus.v_high : 3'h0;
    next_r.i_high = enabled ? cmp_bus.i_high : 3'h0;
    next_r.state = new_state;
    if (new_state == lsd_pkg::LSD_LIVE) begin
      if (r.live_cnt < lsd_pkg::CNT_W'(lsd_pkg::LIVE_QUAL_CYC - 1)) begin
        next_r.live_cnt = r.live_cnt + 1'b1;
      end else begin
        next_r.live_qual = 1'b1;
      end
    end else begin
      next_r.live_cnt = '0;
      next_r.live_qual = 1'b0;
    end
    // state change events: entered dead, entered live, qualified live, left live
    new_ev[0] = (new_state == lsd_pkg::LSD_DEAD) && (r.state != lsd_pkg::LSD_DEAD);
    new_ev[1] = (new_state == lsd_pkg::LSD_LIVE) && (r.state != lsd_pkg::LSD_LIVE);
    new_ev[2] = next_r.live_qual && !r.live_qual;
    new_ev[3] = (new_state != lsd_pkg::LSD_LIVE) && (r.state == lsd_pkg::LSD_LIVE);
    next_r.rdata = 32'h0;
    if (apb_wr) begin
      unique case (PADDR)
        lsd_pkg::CTRL_OFF: begin
          next_r.on = PWDATA[lsd_pkg::CTRL_ON_BIT];
        end
        lsd_pkg::THRESH_OFF: begin
          next_r.vth = clip_pct(PWDATA[lsd_pkg::VTH_LSB +: 8], lsd_pkg::VTH_MIN,
                                lsd_pkg::VTH_MAX);
          next_r.ith = clip_pct(PWDATA[lsd_pkg::ITH_LSB +: 8], lsd_pkg::ITH_MIN,
                                lsd_pkg::ITH_MAX);
        end
        lsd_pkg::MASK_OFF: begin
          next_r.mask = PWDATA[lsd_pkg::EV_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
    // read clears only the bits already shown in read data; a new event wins
    if (apb_rd && PADDR == lsd_pkg::EVENT_OFF) begin
      next_r.events = (r.events & ~r.rdata[lsd_pkg::EV_WIDTH-1:0]) | new_ev;
    end else begin
      next_r.events = r.events | new_ev;
    end
    // load in the setup cycle so data stands through the zero-wait access phase
    if (apb_setup_rd) begin
      unique case (PADDR)
        lsd_pkg::CTRL_OFF: next_r.rdata = {31'h0, r.on};
        lsd_pkg::THRESH_OFF: next_r.rdata = {16'h0, r.ith, r.vth};
        lsd_pkg::STATUS_OFF: next_r.rdata = {23'h0, r.live_qual,
          r.state == lsd_pkg::LSD_LIVE, r.state == lsd_pkg::LSD_DEAD, r.i_high, r.v_high};
        lsd_pkg::EVENT_OFF: next_r.rdata = {28'h0, r.events};
        lsd_pkg::MASK_OFF: next_r.rdata = {28'h0, r.mask};
        lsd_pkg::LIVE_OFF: next_r.rdata = {6'h0, r.live_cnt};
        default: next_r.rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      r.on <= lsd_pkg::CTRL_ON_RESET;
      r.vth <= lsd_pkg::VTH_RESET;
      r.ith <= lsd_pkg::ITH_RESET;
      r.v_high <= 3'h0;
      r.i_high <= 3'h0;
      r.state <= lsd_pkg::LSD_OFF;
      r.live_cnt <= '0;
      r.live_qual <= 1'b0;
      r.events <= lsd_pkg::EV_RESET;
      r.mask <= lsd_pkg::EV_RESET;
      r.rdata <= 32'h0;
    end else if (CE) begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // read data is registered in the setup cycle, so the access phase is one cycle
  assign PRDATA = r.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign PHASE1_VOLTAGE_HIGH = r.v_high[0];
  assign PHASE2_VOLTAGE_HIGH = r.v_high[1];
  assign PHASE3_VOLTAGE_HIGH = r.v_high[2];
  assign PHASE1_CURRENT_HIGH = r.i_high[0];
  assign PHASE2_CURRENT_HIGH = r.i_high[1];
  assign PHASE3_CURRENT_HIGH = r.i_high[2];
  assign LINE_DEAD_OUT = r.state == lsd_pkg::LSD_DEAD;
  assign LINE_LIVE_OUT = r.state == lsd_pkg::LSD_LIVE;
  assign LINE_LIVE_QUALIFIED = r.live_qual;
  assign IRQ = |(r.events & r.mask);

  ////////////////////////////////////////////////////////////////////////////

  dead_needs_all_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && enabled && !(&cmp_bus.v_low && &cmp_bus.i_low) |=> !LINE_DEAD_OUT)
    else $error("dead asserted without all phases low");

  live_follows_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && enabled && live_cond |=> LINE_LIVE_OUT)
    else $error("live missing with all voltages high");

  vflag_track_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && enabled |=> PHASE1_VOLTAGE_HIGH == $past(cmp_bus.v_high[0]))
    else $error("phase voltage flag wrong");

  iflag_track_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && enabled |=> PHASE3_CURRENT_HIGH == $past(cmp_bus.i_high[2]))
    else $error("phase current flag wrong");

  dead_live_excl_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !(LINE_DEAD_OUT && LINE_LIVE_OUT))
    else $error("dead and live both high");

  block_quiet_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && !enabled |=> !LINE_DEAD_OUT && !LINE_LIVE_OUT && !PHASE2_VOLTAGE_HIGH
      && !PHASE2_CURRENT_HIGH)
    else $error("outputs active while disabled");

  neutral_low_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && enabled && !dead_cond && !live_cond |=> !LINE_DEAD_OUT && !LINE_LIVE_OUT)
    else $error("indication high with no condition");

  qual_needs_live_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    LINE_LIVE_QUALIFIED |-> LINE_LIVE_OUT && r.live_cnt == lsd_pkg::CNT_W'(
      lsd_pkg::LIVE_QUAL_CYC - 1))
    else $error("qualified live without full persistence");

  thr_range_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    r.vth >= lsd_pkg::VTH_MIN && r.vth <= lsd_pkg::VTH_MAX && r.ith >= lsd_pkg::ITH_MIN)
    else $error("threshold out of range");

endmodule

// file: verif/lsd_meas_model.sv
// measurement front end model: presents three-phase magnitudes
// assumes the bench hands it one sample set per clock

`timescale 1ns/100ps

module lsd_meas_model (
  // clock
  input wire logic clk,
  // requested set, currents in [47:24], voltages in [23:0]
  input wire logic [47:0] req,
  // magnitudes in percent of rated value
  output logic [7:0] v1,
  output logic [7:0] v2,
  output logic [7:0] v3,
  output logic [7:0] c1,
  output logic [7:0] c2,
  output logic [7:0] c3
);
  // registered so samples move just after an edge, never on it
  always_ff @(posedge clk) begin
    {c3, c2, c1, v3, v2, v1} <= req;
  end
endmodule

// file: verif/tb.sv
// self-checking bench for the line state detector
// assumes zero-wait apb and one-cycle output latency

`timescale 1ns/100ps

module tb;
  localparam int LIMIT = 5000;
  localparam logic [47:0] LIVE = 48'h000000505050;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic blk = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic [47:0] req = 48'h0;
  logic [7:0] v1, v2, v3, c1, c2, c3;
  logic [8:0] got;
  logic [8:0] exp_q = 9'h0;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 32'h0dd3fb5a;
  int on_m = 1;
  int vth_m = 60;
  int ith_m = 10;

  initial begin
    forever #2 clk = ~clk;
  end

  lsd_meas_model lsd_meas_model_inst (.clk(clk), .req(req), .v1(v1), .v2(v2), .v3(v3),
    .c1(c1), .c2(c2), .c3(c3));

  line_state_detector line_state_detector_inst (.CLOCK(clk), .RSTN(rstn), .CE(1'b1),
    .PHASE1_VOLTAGE(v1), .PHASE2_VOLTAGE(v2), .PHASE3_VOLTAGE(v3),
    .PHASE1_CURRENT(c1), .PHASE2_CURRENT(c2), .PHASE3_CURRENT(c3),
    .DETECTOR_BLOCK_IN(blk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PHASE1_VOLTAGE_HIGH(got[6]), .PHASE2_VOLTAGE_HIGH(got[7]), .PHASE3_VOLTAGE_HIGH(got[8]),
    .PHASE1_CURRENT_HIGH(got[3]), .PHASE2_CURRENT_HIGH(got[4]), .PHASE3_CURRENT_HIGH(got[5]),
    .LINE_DEAD_OUT(got[2]), .LINE_LIVE_OUT(got[1]), .LINE_LIVE_QUALIFIED(got[0]), .IRQ(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // answer taken at the completing edge, request released only after it
    r = prdata;
    e = pslverr;
    if (n >= 50)
      n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input int n, input logic with_blk);
    int r;
    logic [47:0] s;
    repeat (n) begin
      @(posedge clk);
      r = $random(seed);
      // shared base plus small jitter so all-phase conditions really occur
      for (int i = 0; i < 3; i++) begin
        s[8*i +: 8] = {1'b0, r[6:0]} + 8'(r[16+2*i +: 2]);
        s[24+8*i +: 8] = {3'h0, r[12:8]} + 8'(r[22+2*i +: 2]);
      end
      req <= s;
      blk <= with_blk & r[31];
    end
  endtask

  task automatic setm(input logic [47:0] x);
    @(posedge clk);
    req <= x;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reference model: expectation from inputs seen at this edge
  always @(posedge clk) begin
    cyc++;
    if (!rstn) begin
      exp_q = 9'h0;
      on_m = 1;
      vth_m = 60;
      ith_m = 10;
    end else begin
      exp_q[8:6] = {v3 > vth_m, v2 > vth_m, v1 > vth_m};
      exp_q[5:3] = {c3 > ith_m, c2 > ith_m, c1 > ith_m};
      exp_q[2] = v1 < vth_m && v2 < vth_m && v3 < vth_m && c1 < ith_m && c2 < ith_m
                 && c3 < ith_m;
      exp_q[1] = &exp_q[8:6];
      // qualification needs 200 ms, far beyond this run
      exp_q[0] = 1'b0;
      if (on_m == 0 || blk)
        exp_q = 9'h0;
      if (psel && penable && pwrite && pready === 1'b1) begin
        if (paddr == lsd_pkg::CTRL_OFF)
          on_m = pwdata[0];
        if (paddr == lsd_pkg::THRESH_OFF) begin
          vth_m = pwdata[7:0] < lsd_pkg::VTH_MIN ? lsd_pkg::VTH_MIN :
                  pwdata[7:0] > lsd_pkg::VTH_MAX ? lsd_pkg::VTH_MAX : pwdata[7:0];
          ith_m = pwdata[15:8] < lsd_pkg::ITH_MIN ? lsd_pkg::ITH_MIN :
                  pwdata[15:8] > lsd_pkg::ITH_MAX ? lsd_pkg::ITH_MAX : pwdata[15:8];
        end
      end
    end
    if (cyc == LIMIT) begin
      n_mismatch++;
      final_report();
    end
  end

  always @(negedge clk) begin
    chk(32'(got), 32'(exp_q));
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] tv [4];
    tv = '{32'h0305, 32'h6464, 32'h7080, 32'h112A};
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, lsd_pkg::CTRL_OFF, 32'h0, rd, err);
    chk(rd, 32'h1);
    apb(1'b0, lsd_pkg::THRESH_OFF, 32'h0, rd, err);
    chk(rd, 32'h0A3C);
    run(400, 1'b0);
    $display("test default thresholds done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, lsd_pkg::THRESH_OFF, tv[k], rd, err);
      apb(1'b0, lsd_pkg::THRESH_OFF, 32'h0, rd, err);
      chk(rd, 32'((ith_m << 8) | vth_m));
      run(200, 1'b1);
    end
    $display("test thresholds and block done");
    apb(1'b1, lsd_pkg::CTRL_OFF, 32'h0, rd, err);
    run(100, 1'b0);
    apb(1'b1, lsd_pkg::CTRL_OFF, 32'h1, rd, err);
    $display("test operation off done");
    setm(LIVE);
    apb(1'b1, lsd_pkg::MASK_OFF, 32'h1, rd, err);
    apb(1'b0, lsd_pkg::EVENT_OFF, 32'h0, rd, err);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    setm(48'h0);
    chk(32'(irq), 32'h1);
    apb(1'b0, lsd_pkg::EVENT_OFF, 32'h0, rd, err);
    chk(rd & 32'h1, 32'h1);
    setm(LIVE);
    chk(32'(irq), 32'h0);
    apb(1'b1, lsd_pkg::MASK_OFF, 32'h2, rd, err);
    setm(LIVE);
    chk(32'(irq), 32'h1);
    $display("test events done");
    apb(1'b0, 8'hFC, 32'h0, rd, err);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    $display("test unmapped access done");
    final_report();
  end
endmodule
